/* File: hdl/asp_pkg.sv */
// Constants, field layouts and types of the converter serial port.
// Assumes a single ref_clk domain; the port synchronises its own pins.
// What this block does
// R1: Chip select falling starts a conversion; its low time frames one transfer.
// R2: Control bits on the serial input are taken on rising serial clock edges.
// R3: Each falling serial clock edge puts the next result bit on the output.
// R4: A frame is four zero bits, then the 12-bit result, MSB first.
// R5: The serial clock also steps the conversion; no clock, no progress.
// R6: The three-bit channel field picks which of eight inputs is converted.
// R7: A transfer lasts 16 serial clocks; control in and result out together.
// R8: Only the first 8 rising edges load the control word, first bit is MSB.
// R9: A new channel value applies after the current conversion, to the next one.
// R10: Control word resets to zero; host writes the reserved bit as zero.
// R11: Serial output is released while chip select is high, driven within frames.
package asp_pkg;

  // Frame and word shape
  localparam int RES_W = 12;
  localparam int CTL_BITS = 8;
  localparam int LEAD_ZEROS = 4;
  localparam int FRAME_BITS = 16;
  localparam int NUM_CHANNELS = 8;
  localparam int CNT_W = 5;

  // Rising edges spent tracking before the first bit decision
  localparam int ACQ_RISES = 2;

  // Result buffer depth
  localparam int FIFO_DEPTH = 16;

  // Control word field positions
  localparam int CTL_ZERO_BIT = 6;
  localparam int CTL_CHAN_LO = 3;
  localparam int CTL_REF_BIT = 2;
  localparam int CTL_PM_LO = 0;

  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] PINS_IDLE = 4'h1;

  // Control word as shifted in, MSB first
  typedef struct packed {
    logic dontCare;
    logic zeroBit;
    logic [2:0] channel_select;
    logic refDisable;
    logic [1:0] power_mode_field;
  } asp_ctl_t;

  // Pins sampled together; chip select idles high
  typedef struct packed {
    logic cmp;
    logic din;
    logic sclk;
    logic csN;
  } asp_pins_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_TRACK = 2'b01,
    CV_SAR = 2'b10,
    CV_HOLD = 2'b11
  } asp_conv_t;

endpackage

/* File: hdl/asp_fifo.sv */
// Result buffer between the conversion sequencer and the serial output.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = asp_pkg::RES_W,
  parameter int DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two of at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("asp_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign empty = (wrPtr_reg == rdPtr_reg);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_reg[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // Write pointer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
    end else if (inValid && !full) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdPtr_reg <= '0;
    end else if (outReady && !empty) begin
      rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/asp_serial_port.sv */
// Serial port and successive-approximation sequencer of the converter.
// Assumes the host pins and the comparator are asynchronous to ref_clk,
// and that ref_clk runs well above the serial clock.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port #(
  parameter int RES_W = asp_pkg::RES_W,
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic cmpIn,
  output logic sdo,
  output logic sdoOe,
  output logic [RES_W-1:0] dacCode,
  output logic sampleHold,
  output logic [2:0] channelSel,
  output logic refDisable,
  output logic [1:0] powerMode,
  output logic convBusy
);

  localparam int IW = $clog2(RES_W);
  localparam logic [4:0] RISE_MAX = 5'(asp_pkg::FRAME_BITS);
  localparam logic [4:0] FALL_MAX = 5'(asp_pkg::FRAME_BITS);
  localparam logic [4:0] CTL_LAST = 5'(asp_pkg::CTL_BITS - 1);
  localparam logic [4:0] TRACK_LAST = 5'(asp_pkg::ACQ_RISES - 1);
  localparam logic [4:0] ZERO_FALLS = 5'(asp_pkg::LEAD_ZEROS);

  // The frame shape fixes the result width
  if (RES_W != asp_pkg::FRAME_BITS - asp_pkg::LEAD_ZEROS) begin : g_bad_width
    $error("asp_serial_port: RES_W must fill the frame after the leading zeros");
  end

  // Edge test on two samples of one synchronised pin
  function automatic logic edgeSeen(input logic last, input logic now, input logic rising);
    edgeSeen = rising ? (!last && now) : (last && !now);
  endfunction

  asp_pkg::asp_pins_t pinMeta_reg;
  asp_pkg::asp_pins_t pinSync_reg;
  logic csLast_reg;
  logic sclkLast_reg;
  logic inFrame;
  logic frameStart;
  logic sclkRise;
  logic sclkFall;
  logic [4:0] riseCnt_reg;
  logic [4:0] fallCnt_reg;
  logic [6:0] ctlShift_reg;
  asp_pkg::asp_ctl_t ctlWord_reg;
  logic ctlCommit;
  logic [asp_pkg::FRAME_BITS-1:0] txShift_reg;
  logic [asp_pkg::FRAME_BITS-1:0] txLoad;
  logic sdo_reg;
  logic sdoOe_reg;
  asp_pkg::asp_conv_t cv_reg;
  logic convBusy_reg;
  logic sampleHold_reg;
  logic [RES_W-1:0] dac_reg;
  logic [IW-1:0] bitIdx_reg;
  logic [RES_W-1:0] result_reg;
  logic convDone;
  logic [2:0] chanActive_reg;
  logic refDisable_reg;
  logic [1:0] powerMode_reg;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [RES_W-1:0] fifoOutData;

  // Two-stage synchronisers for every asynchronous input
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinMeta_reg <= asp_pkg::PINS_IDLE;
      pinSync_reg <= asp_pkg::PINS_IDLE;
    end else begin
      pinMeta_reg <= {cmpIn, sdi, sclk, csN};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Previous synchronised levels for edge finding
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      csLast_reg <= 1'b1;
      sclkLast_reg <= 1'b0;
    end else begin
      csLast_reg <= pinSync_reg.csN;
      sclkLast_reg <= pinSync_reg.sclk;
    end
  end

  // Frame and serial clock events
  assign inFrame = !pinSync_reg.csN;
  assign frameStart = edgeSeen(csLast_reg, pinSync_reg.csN, 1'b0); // R1
  assign sclkRise = inFrame && edgeSeen(sclkLast_reg, pinSync_reg.sclk, 1'b1);
  assign sclkFall = inFrame && edgeSeen(sclkLast_reg, pinSync_reg.sclk, 1'b0);

  // Rising edges counted per frame, held at the frame length
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      riseCnt_reg <= '0;
    end else if (frameStart) begin
      riseCnt_reg <= '0; // R1
    end else if (sclkRise && riseCnt_reg != RISE_MAX) begin
      riseCnt_reg <= riseCnt_reg + 1'b1; // R7
    end
  end

  // Control bits shift in on rising edges; the word commits on the eighth
  assign ctlCommit = sclkRise && !frameStart && (riseCnt_reg == CTL_LAST); // R8
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctlShift_reg <= '0;
      ctlWord_reg <= asp_pkg::CTL_RESET; // R10
    end else if (sclkRise && !frameStart && riseCnt_reg < CTL_LAST) begin
      ctlShift_reg <= {ctlShift_reg[5:0], pinSync_reg.din}; // R2
    end else if (ctlCommit) begin
      ctlWord_reg <= {ctlShift_reg, pinSync_reg.din}; // R8
    end
  end

  // Oldest buffered result leaves at frame start; none gives zeros
  assign fifoPop = frameStart && fifoOutValid;
  assign txLoad = {{asp_pkg::LEAD_ZEROS{1'b0}}, (fifoOutValid ? fifoOutData : {RES_W{1'b0}})}; // R4

  // Output shifter: first bit shown at frame start, next on each fall
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      txShift_reg <= '0;
      sdo_reg <= 1'b0;
      fallCnt_reg <= '0;
    end else if (frameStart) begin
      txShift_reg <= txLoad;
      sdo_reg <= txLoad[asp_pkg::FRAME_BITS-1]; // R4
      fallCnt_reg <= '0;
    end else if (sclkFall && fallCnt_reg != FALL_MAX) begin
      txShift_reg <= {txShift_reg[asp_pkg::FRAME_BITS-2:0], 1'b0};
      sdo_reg <= txShift_reg[asp_pkg::FRAME_BITS-2]; // R3
      fallCnt_reg <= fallCnt_reg + 1'b1;
    end
  end

  // Output driven only while chip select is low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sdoOe_reg <= 1'b0;
    end else begin
      sdoOe_reg <= inFrame; // R11
    end
  end

  // Last bit decision of the conversion
  assign convDone = (cv_reg == asp_pkg::CV_SAR) && inFrame && sclkRise && (bitIdx_reg == '0);

  // Conversion sequencer, started by chip select falling and stepped by serial clock rises
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cv_reg <= asp_pkg::CV_IDLE;
      convBusy_reg <= 1'b0;
    end else begin
      case (cv_reg)
        asp_pkg::CV_IDLE: begin
          if (frameStart) begin
            cv_reg <= asp_pkg::CV_TRACK; // R1
            convBusy_reg <= 1'b1;
          end
        end
        asp_pkg::CV_TRACK: begin
          if (!inFrame) begin
            cv_reg <= asp_pkg::CV_IDLE;
            convBusy_reg <= 1'b0;
          end else if (sclkRise && riseCnt_reg == TRACK_LAST) begin
            cv_reg <= asp_pkg::CV_SAR; // R5
          end
        end
        asp_pkg::CV_SAR: begin
          if (!inFrame) begin
            cv_reg <= asp_pkg::CV_IDLE;
            convBusy_reg <= 1'b0;
          end else if (convDone) begin
            cv_reg <= asp_pkg::CV_HOLD;
          end
        end
        asp_pkg::CV_HOLD: begin
          // A full buffer stalls here, so no new conversion starts
          if (fifoInReady) begin
            cv_reg <= asp_pkg::CV_IDLE;
            convBusy_reg <= 1'b0;
          end
        end
        default: begin
          cv_reg <= asp_pkg::CV_IDLE;
          convBusy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Track switch closed from frame start to the end of acquisition
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sampleHold_reg <= 1'b0;
    end else if (cv_reg == asp_pkg::CV_IDLE && frameStart) begin
      sampleHold_reg <= 1'b1;
    end else if (cv_reg != asp_pkg::CV_TRACK || !inFrame || sclkRise && riseCnt_reg == TRACK_LAST) begin
      sampleHold_reg <= 1'b0;
    end
  end

  // Trial code: set a bit, keep it if the comparator says input is higher
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dac_reg <= '0;
      bitIdx_reg <= '0;
    end else if (cv_reg == asp_pkg::CV_IDLE && frameStart) begin
      dac_reg <= '0;
    end else if (cv_reg == asp_pkg::CV_TRACK && inFrame && sclkRise
                 && riseCnt_reg == TRACK_LAST) begin
      dac_reg <= {1'b1, {(RES_W-1){1'b0}}}; // R5
      bitIdx_reg <= IW'(RES_W - 1);
    end else if (cv_reg == asp_pkg::CV_SAR && inFrame && sclkRise) begin
      if (!pinSync_reg.cmp) begin
        dac_reg[bitIdx_reg] <= 1'b0; // R5
      end
      if (bitIdx_reg != '0) begin
        dac_reg[bitIdx_reg - 1'b1] <= 1'b1;
        bitIdx_reg <= bitIdx_reg - 1'b1;
      end
    end
  end

  // Finished code waits here for the buffer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      result_reg <= '0;
    end else if (convDone) begin
      result_reg <= {dac_reg[RES_W-1:1], pinSync_reg.cmp};
    end
  end

  // Settings take effect when the running conversion ends
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chanActive_reg <= '0;
      refDisable_reg <= 1'b0;
      powerMode_reg <= '0;
    end else if (convDone) begin
      chanActive_reg <= ctlWord_reg.channel_select; // R9 R6
      refDisable_reg <= ctlWord_reg.refDisable;
      powerMode_reg <= ctlWord_reg.power_mode_field;
    end
  end

  // Result buffer between conversion and output
  asp_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rstn(rstn),
    .inValid(cv_reg == asp_pkg::CV_HOLD),
    .inReady(fifoInReady),
    .inData(result_reg),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // Outputs straight from flip-flops
  assign sdo = sdo_reg;
  assign sdoOe = sdoOe_reg;
  assign dacCode = dac_reg;
  assign sampleHold = sampleHold_reg;
  assign channelSel = chanActive_reg;
  assign refDisable = refDisable_reg;
  assign powerMode = powerMode_reg;
  assign convBusy = convBusy_reg;

  // Checks on the port's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence frameBegin;
    frameStart && cv_reg == asp_pkg::CV_IDLE;
  endsequence

  sequence tracking;
    cv_reg == asp_pkg::CV_TRACK && sampleHold_reg;
  endsequence

  sequence holding;
    cv_reg == asp_pkg::CV_HOLD;
  endsequence

  chk_frame_start: assert property (frameBegin |=> tracking ##0 sdoOe_reg) // R1
    else $error("frame start did not begin tracking and drive the output");

  chk_oe_release: assert property (!inFrame |=> !sdoOe_reg) // R11
    else $error("output driven while chip select high");

  chk_ctl_commit: assert property ($changed(ctlWord_reg) |-> $past(ctlCommit)) // R2 R8
    else $error("control word changed outside the eighth rising edge");

  chk_sdo_fall: assert property ($changed(sdo_reg) |-> $past(sclkFall) || $past(frameStart)) // R3
    else $error("output bit changed without a falling edge");

  chk_lead_zeros: assert property (sdoOe_reg && fallCnt_reg < ZERO_FALLS |-> !sdo_reg) // R4
    else $error("leading bits of the frame are not zero");

  chk_dac_steps: assert property ($changed(dac_reg) |-> $past(sclkRise) || $past(frameStart)) // R5
    else $error("conversion stepped without a serial clock rise");

  chk_done_edge: assert property (convDone |-> riseCnt_reg == 5'd13) // R7
    else $error("conversion did not finish on the fourteenth rise");

  chk_chan_load: assert property (convDone |=> holding ##0
                                  channelSel == $past(ctlWord_reg.channel_select)) // R6
    else $error("channel not taken from control word at conversion end");

  chk_chan_hold: assert property ($changed(chanActive_reg) |-> $past(convDone)) // R9
    else $error("channel changed before the conversion ended");

  chk_ctl_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
                                  !rstn |=> ctlWord_reg == asp_pkg::CTL_RESET) // R10
    else $error("control word not cleared by reset");

endmodule
`default_nettype wire

/* File: testbench/asp_host_model.sv */
// Host controller model driving chip select, serial clock and serial input.
// Assumes the bench calls frame from its main thread; sclk idles low.
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
  input wire logic clk,
  output logic csN,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOe
);
  // Half period of the 80 ns serial clock in ref_clk cycles
  localparam int HALF = 10;
  int riseCnt;
  logic lastSdo;
  logic sdoWire;

  // Released line shows the inverse of its last driven level
  always_ff @(posedge clk) begin
    if (sdoOe) begin
      lastSdo <= sdo;
    end
  end
  assign sdoWire = sdoOe ? sdo : ~lastSdo;

  // Idle pins at time zero
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    riseCnt = 0;
  end

  // Waits n edges, then steps just past the edge
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One framed transfer; rx captured on each rising sclk edge
  task automatic frame(input logic [7:0] ctl, input int rises, input int pause,
                       output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    riseCnt = 0;
    waitClk(1);
    csN = 1'b0;
    for (i = 0; i < rises; i++) begin
      sdi = (i < 8) ? ctl[7 - i] : ~ctl[15 - i];
      waitClk(HALF);
      rx = {rx[14:0], sdoWire};
      sclk = 1'b1;
      riseCnt = i + 1;
      waitClk((i == 5) ? HALF + pause : HALF);
      sclk = 1'b0;
    end
    waitClk(HALF);
    csN = 1'b1;
    waitClk(HALF);
  endtask
endmodule
`default_nettype wire

/* File: testbench/asp_serial_port_tb_top.sv */
// Self-checking bench for the converter serial port and its result buffer.
// Assumes a comparator modelled from the trial code and a fixed input per channel.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_tb_top;
  logic ref_clk, rstn, csN, sclk, sdi, cmpIn, sdo, sdoOe, sampleHold, refDisable, convBusy;
  logic [asp_pkg::RES_W-1:0] dacCode;
  logic [2:0] channelSel;
  logic [1:0] powerMode;
  int nFail, nTests, cycles;

  // Input level of each channel is {channel, 9'h15a}
  assign cmpIn = ({channelSel, 9'h15a} >= dacCode);

  asp_serial_port i_asp_serial_port (.ref_clk(ref_clk), .rstn(rstn), .csN(csN),
    .sclk(sclk), .sdi(sdi), .cmpIn(cmpIn), .sdo(sdo), .sdoOe(sdoOe), .dacCode(dacCode),
    .sampleHold(sampleHold), .channelSel(channelSel), .refDisable(refDisable),
    .powerMode(powerMode), .convBusy(convBusy));
  asp_host_model i_asp_host_model (.clk(ref_clk), .csN(csN), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdoOe(sdoOe));

  // Clock at 4 ns
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic closeOut;
    $display("Checks %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      closeOut();
    end
  end

  task automatic testReset;
    check("ctl fields", 16'({channelSel, refDisable, powerMode}), 16'h0000);
    check("sdoOe idle", 16'(sdoOe), 16'h0000);
    check("busy idle", 16'(convBusy), 16'h0000);
  endtask

  // Mid-frame looks: frozen conversion while sclk stops, old channel still applied
  task automatic midCheck(input logic [2:0] ch, input logic paused);
    logic [11:0] d;
    wait (sdoOe === 1'b1);
    @(posedge ref_clk);
    #1;
    check("track early", 16'(sampleHold), 16'h0001);
    wait (i_asp_host_model.riseCnt == 6);
    if (paused) begin
      repeat (20) @(posedge ref_clk);
      #1;
      d = dacCode;
      repeat (60) @(posedge ref_clk);
      #1;
      check("dac frozen", 16'(dacCode), 16'(d));
    end
    wait (i_asp_host_model.riseCnt == 10);
    repeat (5) @(posedge ref_clk);
    #1;
    check("chan mid", 16'(channelSel), 16'(ch));
    check("track mid", 16'(sampleHold), 16'h0000);
    check("sdoOe mid", 16'(sdoOe), 16'h0001);
    check("busy mid", 16'(convBusy), 16'h0001);
  endtask

  // Nine frames walk all channels; result of frame k appears in frame k+1
  task automatic testFrames;
    int k;
    logic [7:0] ctl;
    logic [15:0] rx, exp;
    logic [2:0] prevCh, lastConv;
    prevCh = 3'h0;
    lastConv = 3'h0;
    for (k = 0; k < 9; k++) begin
      ctl = {k[0], 1'b0, k[2:0], k[1], k[1:0]};
      exp = (k == 0) ? 16'h0000 : {4'h0, lastConv, 9'h15a};
      fork
        i_asp_host_model.frame(ctl, 16, (k == 3) ? 80 : 0, rx);
        midCheck(prevCh, k == 3);
      join
      check("frame data", rx, exp);
      lastConv = prevCh;
      prevCh = k[2:0];
      check("ctl applied", 16'({channelSel, refDisable, powerMode}),
            16'({k[2:0], k[1], k[1:0]}));
      check("sdoOe after", 16'(sdoOe), 16'h0000);
    end
  endtask

  // Frame cut before conversion end leaves applied fields alone
  task automatic testAbort;
    logic [15:0] rx;
    i_asp_host_model.frame(8'h3f, 10, 0, rx);
    check("abort rx", rx, 16'h003d);
    repeat (10) @(posedge ref_clk);
    #1;
    check("abort ctl", 16'({channelSel, refDisable, powerMode}), 16'h0000);
  endtask

  // Cut frame emptied the buffer: next frame sends zeros, the one after its result
  task automatic testFifo;
    logic [15:0] rx;
    i_asp_host_model.frame(8'h10, 16, 0, rx);
    check("fifo drain", rx, 16'h0000);
    check("busy after", 16'(convBusy), 16'h0000);
    i_asp_host_model.frame(8'h08, 16, 0, rx);
    check("fifo data", rx, 16'h015a);
    check("fifo ctl", 16'({channelSel, refDisable, powerMode}), 16'h0008);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    nFail = 0;
    nTests = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    testReset();
    testFrames();
    testAbort();
    testFifo();
    closeOut();
  end
endmodule
`default_nettype wire
